// [rtl/uef_cfg.svh]
// constants for the usb event flag register bank
// assumes inclusion by bare name from design files under rtl/
`ifndef UEF_CFG_SVH
`define UEF_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define UEF_OFS_FLAGS1 8'h00
`define UEF_OFS_FLAGS2 8'h04
`define UEF_OFS_EN1 8'h08
`define UEF_OFS_EN2 8'h0c
`define UEF_OFS_SEL1 8'h10
`define UEF_OFS_CTRL 8'h14
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UEF_F1_CABLE 0
`define UEF_F1_DONE 1
`define UEF_F1_TREQ 2
`define UEF_F1_VBUS 3
`define UEF_F2_CFGREQ 0
`define UEF_F2_CFGVAL 1
`define UEF_F2_SUSP 2
`define UEF_F2_AWAKE 3
`define UEF_CTRL_SUSPEND 0
// ----------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------
`define UEF_RSVD_HI 4'h2
`define UEF_FLAGS_RESET 8'h20
`define UEF_BYTE_ZERO 8'h00
`define UEF_STICKY_ZERO 3'h0
`define UEF_PAD_ZERO 24'h000000
`endif

// [rtl/uef_pkg.sv]
// types shared by the usb event flag register bank
// assumes uef_cfg.svh defines the numeric constants
`default_nettype none
package uef_pkg;
  typedef logic [7:0] uef_byte_t;
  typedef logic [2:0] uef_sticky_t;
  typedef enum logic [1:0] {
    UEF_PRIME_WAIT,
    UEF_PRIME_RUN
  } uef_prime_t;
endpackage : uef_pkg
`default_nettype wire

// [rtl/uef_regs.sv]
// usb event flag registers one and two with enables and line select
// assumes all event and pin inputs are synchronous to sys_clk
//
// Overview of operation
// - write 0 clears flag, 1 keeps it
// - bus-power status bit ignores writes
// - flag register one resets to 0x20
// - bit 3 mirrors bus-power pin level
// - in token without data sets request flag
// - nack endpoint three until data armed
// - acked endpoint three send sets done flag
// - attach or detach edge sets cable flag
// - enabled register-one flag raises interrupt
// - enabled register-two flag raises interrupt
// - flag register two resets to 0x20
// - suspended resume or reset sets wake flag
// - suspended bus idle sets suspend flag
// - configuration value bit read-only status
// - configuration request sets bit zero
// - select bit routes flag; line zero wins
// - enabled config request raises priority line
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "uef_cfg.svh"
module uef_regs (
  input wire logic sys_clk, // 10 MHz system clock
  input wire logic rst_b, // synchronous reset, low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic bus_power_pin, // bus power level, 1 connected
  input wire logic connection_detect_pin, // attach detect level
  input wire logic ep3_in_token, // in token for endpoint three
  input wire logic ep3_tx_armed, // data written and send enabled
  input wire logic ep3_ack_rcvd, // host acked endpoint three data
  input wire logic resume_detect, // resume seen on bus
  input wire logic bus_reset_detect, // bus reset seen on bus
  input wire logic suspend_detect, // bus suspend seen
  input wire logic config_value_in, // current configuration value
  input wire logic config_request, // set-configuration request pulse
  output logic ep3_nack_o, // answer in token with nack
  output logic interrupt_line_zero, // interrupt line zero
  output logic interrupt_line_one, // interrupt line one
  output logic high_priority_interrupt_line, // priority request
  output logic irq_o // any enabled flag set
);
  import uef_pkg::*;

  // ----------------------------------------------------------------
  // address decode helper
  // ----------------------------------------------------------------
  function automatic logic adr_hit(input logic [7:0] adr,
                                   input logic [7:0] ofs);
    adr_hit = (adr == ofs);
  endfunction : adr_hit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  uef_byte_t event_enables_one_reg;
  uef_byte_t event_enables_one_next;
  uef_byte_t event_enables_two_reg;
  uef_byte_t event_enables_two_next;
  uef_byte_t event_line_select_one_reg;
  uef_byte_t event_line_select_one_next;
  uef_byte_t bus_power_control_reg;
  uef_byte_t bus_power_control_next;
  logic bus_power_present_status_reg;
  logic config_value_status_reg;
  logic cable_prev_reg;
  uef_prime_t prime_reg;
  uef_prime_t prime_next;
  logic ep3_nack_reg;
  logic line_zero_reg;
  logic line_one_reg;
  logic hp_line_reg;
  logic irq_reg;
  uef_sticky_t set_one;
  uef_sticky_t clr_one;
  uef_sticky_t set_two;
  uef_sticky_t clr_two;
  uef_sticky_t sticky_one;
  uef_sticky_t sticky_two;
  uef_byte_t event_flags_one;
  uef_byte_t event_flags_two;
  uef_byte_t rdata;
  uef_byte_t wbyte;
  uef_byte_t pend_one;
  logic wr_commit;
  logic wr_flags1;
  logic wr_flags2;
  logic wr_en1;
  logic wr_en2;
  logic wr_sel1;
  logic wr_ctrl;
  logic suspend_on;
  logic cable_edge;
  logic ep3_starved;
  logic line_zero_next;
  logic line_one_next;
  logic hp_next;
  logic irq_next;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // handshake and read capture
  uef_wb_slave u_slave (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel0_i(wb_sel_i[0]),
    .rdata_i(rdata),
    .wb_ack_reg(wb_ack_o),
    .wb_dat_reg(wb_dat_o),
    .wr_commit(wr_commit)
  );

  // write strobes per register
  assign wbyte = wb_dat_i[7:0];
  assign wr_flags1 = wr_commit & adr_hit(wb_adr_i, `UEF_OFS_FLAGS1);
  assign wr_flags2 = wr_commit & adr_hit(wb_adr_i, `UEF_OFS_FLAGS2);
  assign wr_en1 = wr_commit & adr_hit(wb_adr_i, `UEF_OFS_EN1);
  assign wr_en2 = wr_commit & adr_hit(wb_adr_i, `UEF_OFS_EN2);
  assign wr_sel1 = wr_commit & adr_hit(wb_adr_i, `UEF_OFS_SEL1);
  assign wr_ctrl = wr_commit & adr_hit(wb_adr_i, `UEF_OFS_CTRL);

  // read mux, unmapped addresses read zero
  assign rdata =
    adr_hit(wb_adr_i, `UEF_OFS_FLAGS1) ? event_flags_one :
    adr_hit(wb_adr_i, `UEF_OFS_FLAGS2) ? event_flags_two :
    adr_hit(wb_adr_i, `UEF_OFS_EN1) ? event_enables_one_reg :
    adr_hit(wb_adr_i, `UEF_OFS_EN2) ? event_enables_two_reg :
    adr_hit(wb_adr_i, `UEF_OFS_SEL1) ? event_line_select_one_reg :
    adr_hit(wb_adr_i, `UEF_OFS_CTRL) ? bus_power_control_reg :
    `UEF_BYTE_ZERO;

  // ----------------------------------------------------------------
  // flag register one
  // ----------------------------------------------------------------
  // capture-then-arm so the first sample after reset is no event
  assign prime_next = UEF_PRIME_RUN;
  assign cable_edge = (prime_reg == UEF_PRIME_RUN) &
                      (connection_detect_pin != cable_prev_reg);
  assign ep3_starved = ep3_in_token & ~ep3_tx_armed;

  // hardware set requests for register one
  assign set_one[`UEF_F1_CABLE] = cable_edge;
  assign set_one[`UEF_F1_DONE] = ep3_ack_rcvd;
  assign set_one[`UEF_F1_TREQ] = ep3_starved;

  // writing zero clears, writing one keeps
  assign clr_one = wr_flags1 ? ~wbyte[2:0] : `UEF_STICKY_ZERO;

  // sticky part of register one
  uef_sticky u_flags_one (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .set_i(set_one),
    .clr_i(clr_one),
    .flags_reg(sticky_one)
  );

  // read view: reserved pattern, live bus-power bit, sticky flags
  assign event_flags_one = {`UEF_RSVD_HI,
                            bus_power_present_status_reg,
                            sticky_one};

  // ----------------------------------------------------------------
  // flag register two
  // ----------------------------------------------------------------
  assign suspend_on = bus_power_control_reg[`UEF_CTRL_SUSPEND];

  // hardware set requests for register two
  assign set_two[`UEF_F2_CFGREQ] = config_request;
  assign set_two[1] = suspend_on & suspend_detect;
  assign set_two[2] = suspend_on &
                      (resume_detect | bus_reset_detect);

  // sticky order: config request, suspend, awake; status bit skipped
  assign clr_two = wr_flags2 ? ~{wbyte[`UEF_F2_AWAKE],
                                 wbyte[`UEF_F2_SUSP],
                                 wbyte[`UEF_F2_CFGREQ]} :
                   `UEF_STICKY_ZERO;

  // sticky part of register two
  uef_sticky u_flags_two (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .set_i(set_two),
    .clr_i(clr_two),
    .flags_reg(sticky_two)
  );

  // read view with read-only configuration value bit
  assign event_flags_two = {`UEF_RSVD_HI,
                            sticky_two[2],
                            sticky_two[1],
                            config_value_status_reg,
                            sticky_two[0]};

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // reserved enable and select bits stay zero
  assign event_enables_one_next = wr_en1 ?
    {5'h00, wbyte[2:0]} : event_enables_one_reg;
  assign event_enables_two_next = wr_en2 ?
    {7'h00, wbyte[0]} : event_enables_two_reg;
  assign event_line_select_one_next = wr_sel1 ?
    {5'h00, wbyte[2:0]} : event_line_select_one_reg;
  assign bus_power_control_next = wr_ctrl ?
    {7'h00, wbyte[0]} : bus_power_control_reg;

  // storage for software-written registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      event_enables_one_reg <= `UEF_BYTE_ZERO;
      event_enables_two_reg <= `UEF_BYTE_ZERO;
      event_line_select_one_reg <= `UEF_BYTE_ZERO;
      bus_power_control_reg <= `UEF_BYTE_ZERO;
    end else begin
      event_enables_one_reg <= event_enables_one_next;
      event_enables_two_reg <= event_enables_two_next;
      event_line_select_one_reg <= event_line_select_one_next;
      bus_power_control_reg <= bus_power_control_next;
    end
  end

  // ----------------------------------------------------------------
  // status sampling and endpoint three answer
  // ----------------------------------------------------------------
  // live status bits, cable history, nack answer
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bus_power_present_status_reg <= 1'b0;
      config_value_status_reg <= 1'b0;
      cable_prev_reg <= 1'b0;
      prime_reg <= UEF_PRIME_WAIT;
      ep3_nack_reg <= 1'b0;
    end else begin
      bus_power_present_status_reg <= bus_power_pin;
      config_value_status_reg <= config_value_in;
      cable_prev_reg <= connection_detect_pin;
      prime_reg <= prime_next;
      ep3_nack_reg <= ep3_starved;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request lines
  // ----------------------------------------------------------------
  assign pend_one = event_flags_one & event_enables_one_reg;
  assign line_zero_next = |(pend_one & ~event_line_select_one_reg);
  assign line_one_next = ~line_zero_next &
                         (|(pend_one & event_line_select_one_reg));
  assign hp_next = event_flags_two[`UEF_F2_CFGREQ] &
                   event_enables_two_reg[`UEF_F2_CFGREQ];
  assign irq_next = (|pend_one) | hp_next;

  // registered request outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      line_zero_reg <= 1'b0;
      line_one_reg <= 1'b0;
      hp_line_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      line_zero_reg <= line_zero_next;
      line_one_reg <= line_one_next;
      hp_line_reg <= hp_next;
      irq_reg <= irq_next;
    end
  end

  assign ep3_nack_o = ep3_nack_reg;
  assign interrupt_line_zero = line_zero_reg;
  assign interrupt_line_one = line_one_reg;
  assign high_priority_interrupt_line = hp_line_reg;
  assign irq_o = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_vbus_mirror: assert property (
    ##1 event_flags_one[`UEF_F1_VBUS] == $past(bus_power_pin))
    else $error("bus power bit not mirroring pin");

  a_vbus_nowrite: assert property (
    wr_flags1 && !wbyte[`UEF_F1_VBUS] && bus_power_pin
    |=> event_flags_one[`UEF_F1_VBUS])
    else $error("bus power bit cleared by write");

  a_treq_nack: assert property (
    ep3_in_token && !ep3_tx_armed
    |=> event_flags_one[`UEF_F1_TREQ] && ep3_nack_o)
    else $error("starved in token not flagged");

  a_armed_nonack: assert property (
    ep3_in_token && ep3_tx_armed |=> !ep3_nack_o)
    else $error("nack while data armed");

  a_done_set: assert property (
    ep3_ack_rcvd |=> event_flags_one[`UEF_F1_DONE])
    else $error("transmit done flag not set");

  a_cable_set: assert property (
    prime_reg == UEF_PRIME_RUN && $changed(connection_detect_pin)
    |=> event_flags_one[`UEF_F1_CABLE])
    else $error("cable flag not set on edge");

  a_clear_zero: assert property (
    wr_flags1 && !wbyte[`UEF_F1_DONE] && !ep3_ack_rcvd
    |=> !event_flags_one[`UEF_F1_DONE])
    else $error("write zero did not clear flag");

  a_keep_one: assert property (
    wr_flags2 && wbyte[`UEF_F2_CFGREQ] && event_flags_two[`UEF_F2_CFGREQ]
    |=> event_flags_two[`UEF_F2_CFGREQ])
    else $error("write one changed flag");

  a_set_wins: assert property (
    wr_flags2 && !wbyte[`UEF_F2_CFGREQ] && config_request
    |=> event_flags_two[`UEF_F2_CFGREQ])
    else $error("event lost under clear");

  a_awake_gate: assert property (
    !suspend_on && !event_flags_two[`UEF_F2_AWAKE]
    |=> !event_flags_two[`UEF_F2_AWAKE])
    else $error("wake flag set outside suspend");

  a_susp_set: assert property (
    suspend_on && suspend_detect |=> event_flags_two[`UEF_F2_SUSP])
    else $error("suspend flag not set");

  a_rsvd_bits: assert property (
    event_flags_one[7:4] == `UEF_RSVD_HI &&
    event_flags_two[7:4] == `UEF_RSVD_HI)
    else $error("reserved bits wrong");

  a_line_route: assert property (
    line_zero_next |=> interrupt_line_zero && !interrupt_line_one)
    else $error("line zero priority broken");

  a_hp_line: assert property (
    event_flags_two[`UEF_F2_CFGREQ] && event_enables_two_reg[`UEF_F2_CFGREQ]
    |=> high_priority_interrupt_line && irq_o)
    else $error("priority request missing");

  a_irq_one: assert property (
    |pend_one |=> irq_o)
    else $error("register one interrupt missing");
endmodule : uef_regs
`default_nettype wire

// [rtl/uef_sticky.sv]
// a small group of sticky event flags
// assumes set and clear are one-cycle requests in the sys_clk domain
`timescale 1ns/10ps
`default_nettype none
`include "uef_cfg.svh"
module uef_sticky (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, low
  input wire uef_pkg::uef_sticky_t set_i, // hardware set requests
  input wire uef_pkg::uef_sticky_t clr_i, // software clear requests
  output var uef_pkg::uef_sticky_t flags_reg // flag values
);
  import uef_pkg::*;
  uef_sticky_t flags_next;
  // clear first, then set, so a same-cycle event survives
  assign flags_next = (flags_reg & ~clr_i) | set_i;
  // flag storage
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flags_reg <= `UEF_STICKY_ZERO;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule : uef_sticky
`default_nettype wire

// [rtl/uef_wb_slave.sv]
// classic wishbone handshake for an 8-bit register bank
// assumes master holds the request until it sees ack
`timescale 1ns/10ps
`default_nettype none
`include "uef_cfg.svh"
module uef_wb_slave (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic wb_sel0_i, // byte lane 0 select
  input wire uef_pkg::uef_byte_t rdata_i, // selected register value
  output logic wb_ack_reg, // acknowledge
  output logic [31:0] wb_dat_reg, // read data
  output logic wr_commit // write takes effect this edge
);
  import uef_pkg::*;
  logic req;
  logic [31:0] dat_next;
  assign req = wb_cyc_i & wb_stb_i;
  // write lands at the edge where the master samples ack
  assign wr_commit = req & wb_we_i & wb_sel0_i & wb_ack_reg;
  // read data captured as ack rises, upper bits zero
  assign dat_next = (req & ~wb_ack_reg & ~wb_we_i) ?
                    {`UEF_PAD_ZERO, rdata_i} : wb_dat_reg;
  // one-wait-state acknowledge, dropped the cycle after
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= {`UEF_PAD_ZERO, `UEF_BYTE_ZERO};
    end else begin
      wb_ack_reg <= req & ~wb_ack_reg;
      wb_dat_reg <= dat_next;
    end
  end
endmodule : uef_wb_slave
`default_nettype wire

// [verif/uef_host_model.sv]
// usb host stand-in: one-cycle bus event pulses on request
// assumes the bench raises ev_go with ev_code for a single edge
`timescale 1ns/10ps
`default_nettype none
module uef_host_model (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, low
  input wire logic ev_go, // request one event
  input wire logic [2:0] ev_code, // event kind, 0 to 5
  output logic ep3_in_token, // in token for endpoint three
  output logic ep3_ack_rcvd, // ack of endpoint three data
  output logic resume_detect, // resume signalling seen
  output logic bus_reset_detect, // bus reset signalling seen
  output logic suspend_detect, // bus suspend seen
  output logic config_request // set-configuration request
);
  // ----------------------------------------------------------------
  // event pulses
  // ----------------------------------------------------------------
  logic [5:0] pulse_reg = 6'h00;
  // one pulse the cycle after a request, idle otherwise
  always @(posedge sys_clk) begin
    pulse_reg <= (rst_b && ev_go) ? (6'h01 << ev_code) : 6'h00;
  end
  assign {config_request, suspend_detect, bus_reset_detect} = pulse_reg[5:3];
  assign {resume_detect, ep3_ack_rcvd, ep3_in_token} = pulse_reg[2:0];
endmodule : uef_host_model
`default_nettype wire

// [verif/usb_event_flag_regs_one_two_test.sv]
// self-checking bench for the usb event flag register bank
// assumes uef_regs and uef_host_model are compiled beforehand
`timescale 1ns/10ps
`default_nettype none
`include "uef_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module usb_event_flag_regs_one_two_test;
  logic sys_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, seed = 32'h55de;
  logic ack, nack, irq_z, irq_o1, irq_hp, irq_any, go = 1'b0;
  logic [2:0] code = 3'h0, s1 = 3'h0, en1 = 3'h0, sel1 = 3'h0;
  logic pin = 1'b0, cdp = 1'b0, configuration_value_status = 1'b0, armed = 1'b0;
  logic s2c = 1'b0, s2s = 1'b0, s2a = 1'b0, en2 = 1'b0, ctrl = 1'b0;
  logic tok, ackr, res, brst, susp, creq;
  int errors = 0, total_checks = 0;
  // ----------------------------------------------------------------
  // design, host and clock
  // ----------------------------------------------------------------
  uef_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bus_power_pin(pin), .connection_detect_pin(cdp),
    .ep3_in_token(tok), .ep3_tx_armed(armed), .ep3_ack_rcvd(ackr),
    .resume_detect(res), .bus_reset_detect(brst),
    .suspend_detect(susp), .config_value_in(configuration_value_status),
    .config_request(creq), .ep3_nack_o(nack),
    .interrupt_line_zero(irq_z), .interrupt_line_one(irq_o1),
    .high_priority_interrupt_line(irq_hp), .irq_o(irq_any));
  uef_host_model host_u (.sys_clk(sys_clk), .rst_b(rst_b), .ev_go(go),
    .ev_code(code), .ep3_in_token(tok), .ep3_ack_rcvd(ackr),
    .resume_detect(res), .bus_reset_detect(brst),
    .suspend_detect(susp), .config_request(creq));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected read value of each mapped register
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      `UEF_OFS_FLAGS1: return {4'h2, pin, s1};
      `UEF_OFS_FLAGS2: return {4'h2, s2a, s2s, configuration_value_status, s2c};
      `UEF_OFS_EN1: return {5'h00, en1};
      `UEF_OFS_EN2: return {7'h00, en2};
      `UEF_OFS_SEL1: return {5'h00, sel1};
      `UEF_OFS_CTRL: return {7'h00, ctrl};
      default: return 8'h00;
    endcase
  endfunction : exp_rd
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // one classic wishbone cycle; evc >= 0 also requests a host event
  task automatic wb_xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] s, input int evc,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    sel <= s;
    if (evc >= 0) begin
      go <= 1'b1;
      code <= 3'(evc);
    end
    do begin
      @(posedge sys_clk);
      go <= 1'b0;
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      print_verdict();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_xfer
  // write with the expected effect on the shadow registers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, a, d, 4'h1, -1, q);
    case (a)
      `UEF_OFS_FLAGS1: s1 = s1 & d[2:0];
      `UEF_OFS_FLAGS2: begin
        s2c = s2c & d[0];
        s2s = s2s & d[2];
        s2a = s2a & d[3];
      end
      `UEF_OFS_EN1: en1 = d[2:0];
      `UEF_OFS_EN2: en2 = d[0];
      `UEF_OFS_SEL1: sel1 = d[2:0];
      `UEF_OFS_CTRL: ctrl = d[0];
      default: ;
    endcase
  endtask : wr
  // one host event, checking the nack answer on each of the four following cycles
  task automatic ev(input logic [2:0] c);
    int n;
    n = 0;
    @(posedge sys_clk);
    go <= 1'b1;
    code <= c;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      `CHK(nack, c == 3'h0 && !armed && n == 1)
      n++;
    end
    case (c)
      3'h0: begin
        if (!armed) s1[2] = 1'b1;
      end
      3'h1: s1[1] = 1'b1;
      3'h2, 3'h3: s2a = s2a | ctrl;
      3'h4: s2s = s2s | ctrl;
      default: s2c = 1'b1;
    endcase
  endtask : ev
  // interrupt outputs, then every mapped register and one unmapped
  task automatic chk_all;
    logic [7:0] q;
    logic [2:0] e1;
    logic z;
    repeat (3) @(posedge sys_clk);
    e1 = s1 & en1;
    z = |(e1 & ~sel1);
    `CHK(irq_z, z)
    `CHK(irq_o1, |(e1 & sel1) & ~z)
    `CHK(irq_hp, s2c & en2)
    `CHK(irq_any, (|e1) | (s2c & en2))
    for (int i = 0; i < 7; i++) begin
      wb_xfer(1'b0, 8'(i * 4), 8'h00, 4'h1, -1, q);
      `CHK({rdat[31:8], q}, {24'h000000, exp_rd(8'(i * 4))})
    end
  endtask : chk_all
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] q, a;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wb_xfer(1'b0, `UEF_OFS_FLAGS1, 8'h00, 4'h1, -1, q);
    `CHK(q, 8'h20)
    wb_xfer(1'b0, `UEF_OFS_FLAGS2, 8'h00, 4'h1, -1, q);
    `CHK(q, 8'h20)
    $display("test reset done");
    // corner cases: every event, write-zero, sel off, set beats clear
    wr(`UEF_OFS_EN1, 8'h07);
    wr(`UEF_OFS_SEL1, 8'h02);
    wr(`UEF_OFS_EN2, 8'h01);
    wr(`UEF_OFS_CTRL, 8'h01);
    pin <= 1'b1;
    configuration_value_status <= 1'b1;
    for (int c = 0; c < 6; c++) ev(3'(c));
    chk_all();
    wb_xfer(1'b1, `UEF_OFS_FLAGS1, 8'h00, 4'h0, -1, q);
    chk_all();
    wr(`UEF_OFS_FLAGS1, 8'hfb);
    chk_all();
    wr(`UEF_OFS_FLAGS1, 8'h00);
    chk_all();
    wb_xfer(1'b1, `UEF_OFS_FLAGS2, 8'hfe, 4'h1, 5, q);
    chk_all();
    armed <= 1'b1;
    ev(3'h0);
    chk_all();
    $display("test corners done");
    // random traffic
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      a = 8'h08 + {4'h0, seed[9:8], 2'b00};
      case (seed[2:0])
        3'h0, 3'h1: ev(seed[5:3] > 3'h5 ? 3'h0 : seed[5:3]);
        3'h2: begin
          if (seed[9] !== cdp) s1[0] = 1'b1;
          pin <= seed[8];
          cdp <= seed[9];
          configuration_value_status <= seed[10];
          armed <= seed[11];
        end
        3'h3: wr(`UEF_OFS_FLAGS1, seed[23:16]);
        3'h4: wr(`UEF_OFS_FLAGS2, seed[23:16]);
        3'h5: wr(a, seed[23:16]);
        default: wr({1'b1, seed[14:8]}, seed[23:16]);
      endcase
      chk_all();
    end
    $display("test random done");
    print_verdict();
  end
endmodule : usb_event_flag_regs_one_two_test
`default_nettype wire
